/* File: design/sys_ctrl_map.vh */
/*
 * Constants for the system reset and test control block: reset hold count,
 * test-mode codes, pin fields and test access port codes.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SYS_CTRL_MAP_VH
`define SYS_CTRL_MAP_VH

// ============================================================
// Reset hold
`define HOLD_CYCLES      16383
`define HOLD_CNT_W       14

// ============================================================
// Test-select codes
`define TMODE_W          3
`define TMODE_FUNC       3'h0
`define TMODE_FLOAT      3'h3

// ============================================================
// General-purpose pins
`define GPIO_W           16
`define DLINE_W          5

// ============================================================
// Test access port
`define IR_W             2
`define IR_RESET         2'h1
`define IR_IDCODE        2'h1
`define IR_BYPASS        2'h3
`define IR_CAPTURE       2'h1
`define ID_W             32
`define ID_VALUE         32'h00000001 // Arbitrary identity value
`define TAP_W            16

`endif

/* File: design/system_reset_test_control.v */
/*
 * System reset and test control: core reset hold after board reset,
 * debug-freeze gating, test-mode decode, general-purpose pin register
 * with delay-line strap capture, and a boundary-scan TAP controller.
 * Assumes all inputs synchronous to i_ref_clk; the scan clock is
 * sampled as an ordinary input and must run well below i_ref_clk/2.
 */
// Notes on behaviour
// - Core stays in reset for 16383 reference clocks after board reset release.
// - Board reset is active low, asynchronous, and resets every register.
// - Debug-freeze command is blocked while the synchronised debug permit, two reference clocks behind the input, is low.
// - Sixteen general-purpose pins connect to an internal register.
// - Low five pins are captured at reset for memory delay-line setup.
// - Test code 000 is functional, 011 floats outputs, others reserved.
// - Scan port follows the standard test access port behaviour.
// - Scan reset input asynchronously resets the test logic.
// - TMS sampled on scan clock rising edge; TDI and TDO timed to it.
`timescale 1ns/1ps
`include "sys_ctrl_map.vh"

module system_reset_test_control #(
    parameter HOLD_CYCLES = `HOLD_CYCLES
) (
    // Clock and board reset
    input  wire                  i_ref_clk,
    input  wire                  i_rst_n,
    // Debug freeze
    input  wire                  i_freeze_cmd,
    input  wire                  i_debug_permit,
    output reg                   o_freeze,
    // Core reset
    output reg                   o_core_rst_n,
    // Test-select decode
    input  wire [`TMODE_W-1:0]   i_test_mode,
    output reg                   o_functional_operation,
    output reg                   o_outputs_float_mode,
    output reg                   o_reserved_mode,
    // General-purpose pins
    input  wire [`GPIO_W-1:0]    i_gpio,
    output reg  [`GPIO_W-1:0]    o_gpio,
    output reg  [`GPIO_W-1:0]    o_gpio_oe,
    input  wire [`GPIO_W-1:0]    i_gpio_drive,
    input  wire [`GPIO_W-1:0]    i_gpio_dir,
    output reg  [`GPIO_W-1:0]    o_user_param,
    output reg  [`DLINE_W-1:0]   o_memory_delay_line,
    // Scan port
    input  wire                  i_trst_n,
    input  wire                  i_tck,
    input  wire                  i_tms,
    input  wire                  i_tdi,
    output reg                   o_tdo,
    output reg                   o_tdo_oe
);

    // ============================================================
    // Core reset hold
    localparam [31:0] HOLD_LAST_W = HOLD_CYCLES - 1;
    localparam [`HOLD_CNT_W-1:0] HOLD_LAST = HOLD_LAST_W[`HOLD_CNT_W-1:0];
    reg  [`HOLD_CNT_W-1:0] hold_cnt;

    // Count reference clocks after release, then free the core
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hold_cnt     <= {`HOLD_CNT_W{1'b0}};
            o_core_rst_n <= 1'b0;
        end else if (!o_core_rst_n) begin
            if (hold_cnt == HOLD_LAST) begin
                o_core_rst_n <= 1'b1;
            end else begin
                hold_cnt <= hold_cnt + 1'b1;
            end
        end
    end

    // ============================================================
    // Debug permit synchroniser and freeze gate
    reg permit_meta;
    reg permit_sync;

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            permit_meta <= 1'b0;
            permit_sync <= 1'b0;
            o_freeze    <= 1'b0;
        end else begin
            permit_meta <= i_debug_permit;
            permit_sync <= permit_meta;
            o_freeze    <= i_freeze_cmd & permit_sync & o_core_rst_n;
        end
    end

    // ============================================================
    // Test mode decode and pin register
    wire float_now = (i_test_mode == `TMODE_FLOAT);

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_functional_operation <= 1'b0;
            o_outputs_float_mode   <= 1'b0;
            o_reserved_mode        <= 1'b0;
            o_gpio                 <= {`GPIO_W{1'b0}};
            o_gpio_oe              <= {`GPIO_W{1'b0}};
            o_user_param           <= {`GPIO_W{1'b0}};
            o_memory_delay_line    <= {`DLINE_W{1'b0}};
        end else begin
            o_functional_operation <= (i_test_mode == `TMODE_FUNC);
            o_outputs_float_mode   <= float_now;
            o_reserved_mode        <= (i_test_mode != `TMODE_FUNC) &&
                                      !float_now;
            o_gpio                 <= i_gpio_drive;
            o_user_param           <= i_gpio;
            if (!o_core_rst_n) begin
                // Strap pins stay undriven and are captured until release
                o_memory_delay_line <= i_gpio[`DLINE_W-1:0];
                o_gpio_oe           <= {`GPIO_W{1'b0}};
            end else if (float_now) begin
                o_gpio_oe <= {`GPIO_W{1'b0}};
            end else begin
                o_gpio_oe <= i_gpio_dir;
            end
        end
    end

    // ============================================================
    // Scan clock edge detection in the reference domain
    wire tap_rst_n = i_rst_n & i_trst_n;
    reg  tck_q;
    wire tck_rise = i_tck & ~tck_q;
    wire tck_fall = ~i_tck & tck_q;

    // ============================================================
    // TAP controller, one-hot states
    localparam [`TAP_W-1:0] S_RESET = 16'h0001;
    localparam [`TAP_W-1:0] S_IDLE  = 16'h0002;
    localparam [`TAP_W-1:0] S_SDR   = 16'h0004;
    localparam [`TAP_W-1:0] S_CDR   = 16'h0008;
    localparam [`TAP_W-1:0] S_SHDR  = 16'h0010;
    localparam [`TAP_W-1:0] S_E1DR  = 16'h0020;
    localparam [`TAP_W-1:0] S_PDR   = 16'h0040;
    localparam [`TAP_W-1:0] S_E2DR  = 16'h0080;
    localparam [`TAP_W-1:0] S_UDR   = 16'h0100;
    localparam [`TAP_W-1:0] S_SIR   = 16'h0200;
    localparam [`TAP_W-1:0] S_CIR   = 16'h0400;
    localparam [`TAP_W-1:0] S_SHIR  = 16'h0800;
    localparam [`TAP_W-1:0] S_E1IR  = 16'h1000;
    localparam [`TAP_W-1:0] S_PIR   = 16'h2000;
    localparam [`TAP_W-1:0] S_E2IR  = 16'h4000;
    localparam [`TAP_W-1:0] S_UIR   = 16'h8000;

    reg  [`TAP_W-1:0] tap;
    reg  [`TAP_W-1:0] next_tap;
    reg  [`IR_W-1:0]  ir;
    reg  [`IR_W-1:0]  ir_sh;
    reg  [`ID_W-1:0]  dr_sh;

    // Standard sixteen-state walk on TMS
    always @* begin
        case (tap)
            S_RESET: next_tap = i_tms ? S_RESET : S_IDLE;
            S_IDLE:  next_tap = i_tms ? S_SDR   : S_IDLE;
            S_SDR:   next_tap = i_tms ? S_SIR   : S_CDR;
            S_CDR:   next_tap = i_tms ? S_E1DR  : S_SHDR;
            S_SHDR:  next_tap = i_tms ? S_E1DR  : S_SHDR;
            S_E1DR:  next_tap = i_tms ? S_UDR   : S_PDR;
            S_PDR:   next_tap = i_tms ? S_E2DR  : S_PDR;
            S_E2DR:  next_tap = i_tms ? S_UDR   : S_SHDR;
            S_UDR:   next_tap = i_tms ? S_SDR   : S_IDLE;
            S_SIR:   next_tap = i_tms ? S_RESET : S_CIR;
            S_CIR:   next_tap = i_tms ? S_E1IR  : S_SHIR;
            S_SHIR:  next_tap = i_tms ? S_E1IR  : S_SHIR;
            S_E1IR:  next_tap = i_tms ? S_UIR   : S_PIR;
            S_PIR:   next_tap = i_tms ? S_E2IR  : S_PIR;
            S_E2IR:  next_tap = i_tms ? S_UIR   : S_SHIR;
            S_UIR:   next_tap = i_tms ? S_SDR   : S_IDLE;
            default: next_tap = S_RESET;
        endcase
    end

    // State, instruction and data registers advance on scan rising edge
    always @(posedge i_ref_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            tck_q <= 1'b0;
            tap   <= S_RESET;
            ir    <= `IR_RESET;
            ir_sh <= {`IR_W{1'b0}};
            dr_sh <= {`ID_W{1'b0}};
        end else begin
            tck_q <= i_tck;
            if (tck_rise) begin
                tap <= next_tap;
                if (tap == S_RESET) begin
                    ir <= `IR_RESET;
                end
                if (tap == S_CIR) begin
                    ir_sh <= `IR_CAPTURE;
                end
                if (tap == S_SHIR) begin
                    ir_sh <= {i_tdi, ir_sh[`IR_W-1:1]};
                end
                if (tap == S_UIR) begin
                    ir <= ir_sh;
                end
                if (tap == S_CDR) begin
                    dr_sh <= (ir == `IR_IDCODE) ? `ID_VALUE
                                                : {`ID_W{1'b0}};
                end
                if (tap == S_SHDR) begin
                    if (ir == `IR_BYPASS) begin
                        dr_sh <= {{(`ID_W-1){1'b0}}, i_tdi};
                    end else begin
                        dr_sh <= {i_tdi, dr_sh[`ID_W-1:1]};
                    end
                end
            end
        end
    end

    // TDO launches on scan falling edge, driven only while shifting;
    // float mode drops the enable at once, it returns at the next fall
    always @(posedge i_ref_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            o_tdo    <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else begin
            if (tck_fall) begin
                o_tdo <= (tap == S_SHIR) ? ir_sh[0] : dr_sh[0];
            end
            if (float_now) begin
                o_tdo_oe <= 1'b0;
            end else if (tck_fall) begin
                o_tdo_oe <= (tap == S_SHIR) || (tap == S_SHDR);
            end
        end
    end

endmodule // system_reset_test_control

/* File: test/scan_tester.sv */
/* Boundary-scan tester model, one bit per call of tap_bit.
   Assumes the reference clock is given and the bench calls the task. */
`timescale 1ns/1ps
module scan_tester (
    // Reference timing
    input  wire logic i_ref_clk,
    // Scan port
    input  wire logic i_tdo,
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi
);
    // Scan clock parked low outside bits
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
    end
    // Set mode and data with clock low, take output, then pulse clock
    task tap_bit(input logic tms_v, input logic tdi_v, output logic tdo_v);
        o_tms = tms_v;
        o_tdi = tdi_v;
        repeat (3) @(negedge i_ref_clk);
        tdo_v = i_tdo;
        o_tck = 1'b1;
        repeat (3) @(negedge i_ref_clk);
        o_tck = 1'b0;
        o_tdi = ~tdi_v; // Data no longer held
    endtask
endmodule // scan_tester

/* File: test/system_reset_test_control_monitor.sv */
/* Port checker for the system reset and test control block.
   Assumes it is bound onto the block and sees only its ports. */
`timescale 1ns/1ps
module sys_ctrl_monitor #(
    parameter HOLD_CYCLES = 8
) (
    // Clock and board reset
    input wire logic        i_ref_clk,
    input wire logic        i_rst_n,
    // Watched inputs
    input wire logic        i_freeze_cmd,
    input wire logic        i_debug_permit,
    input wire logic        i_trst_n,
    input wire logic [2:0]  i_test_mode,
    input wire logic [15:0] i_gpio,
    input wire logic [15:0] i_gpio_dir,
    input wire logic [15:0] i_gpio_drive,
    // Watched outputs
    input wire logic        o_freeze,
    input wire logic        o_core_rst_n,
    input wire logic        o_functional_operation,
    input wire logic        o_outputs_float_mode,
    input wire logic        o_reserved_mode,
    input wire logic [15:0] o_gpio,
    input wire logic [15:0] o_gpio_oe,
    input wire logic [15:0] o_user_param,
    input wire logic [4:0]  o_memory_delay_line,
    input wire logic        o_tdo,
    input wire logic        o_tdo_oe
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // ==========================================================
    // Edges since reset release, saturating at the hold count
    logic [15:0] edges;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            edges <= 16'h0000;
        else if (edges < HOLD_CYCLES)
            edges <= edges + 16'h0001;
    end
    // ==========================================================
    // Properties
    core_hold_a: assert property (o_core_rst_n == (edges >= HOLD_CYCLES))
        else $error("core reset released at wrong edge");
    freeze_block_a: assert property ((!i_debug_permit) [*3] |=> !o_freeze)
        else $error("freeze granted without permit");
    freeze_grant_a: assert property
        (i_debug_permit [*3] ##0 (i_freeze_cmd && o_core_rst_n) |=> o_freeze)
        else $error("freeze not granted");
    mode_decode_a: assert property (o_core_rst_n |=>
        o_functional_operation == ($past(i_test_mode) == 3'h0) &&
        o_outputs_float_mode == ($past(i_test_mode) == 3'h3))
        else $error("test mode decode wrong");
    mode_reserved_a: assert property (o_core_rst_n |=>
        o_reserved_mode != (o_functional_operation || o_outputs_float_mode))
        else $error("reserved flag wrong");
    pins_float_a: assert property
        (o_outputs_float_mode || !o_core_rst_n |-> o_gpio_oe == 16'h0000)
        else $error("pins driven while floating");
    pins_drive_a: assert property
        (o_core_rst_n && $past(o_core_rst_n) && !o_outputs_float_mode |->
        o_gpio_oe == $past(i_gpio_dir) && o_gpio == $past(i_gpio_drive))
        else $error("pin drive wrong");
    user_param_a: assert property (o_core_rst_n |=>
        o_user_param == $past(i_gpio))
        else $error("user parameter not tracking pins");
    delay_hold_a: assert property (o_core_rst_n |=>
        $stable(o_memory_delay_line))
        else $error("delay line setup changed after start");
    scan_reset_a: assert property (!i_trst_n |-> !o_tdo)
        else $error("scan output active in scan reset");
    scan_float_a: assert property (o_outputs_float_mode |-> !o_tdo_oe)
        else $error("scan output driven while floating");
endmodule // sys_ctrl_monitor

bind system_reset_test_control sys_ctrl_monitor #(
    .HOLD_CYCLES(HOLD_CYCLES)
) mon_u (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_trst_n(i_trst_n),
    .i_freeze_cmd(i_freeze_cmd), .i_debug_permit(i_debug_permit),
    .i_test_mode(i_test_mode), .i_gpio(i_gpio), .i_gpio_dir(i_gpio_dir),
    .i_gpio_drive(i_gpio_drive), .o_freeze(o_freeze),
    .o_core_rst_n(o_core_rst_n), .o_reserved_mode(o_reserved_mode),
    .o_functional_operation(o_functional_operation),
    .o_outputs_float_mode(o_outputs_float_mode), .o_gpio(o_gpio),
    .o_gpio_oe(o_gpio_oe), .o_user_param(o_user_param),
    .o_memory_delay_line(o_memory_delay_line), .o_tdo(o_tdo),
    .o_tdo_oe(o_tdo_oe)
);

/* File: test/system_reset_test_control_test.sv */
/* Self-checking bench for the system reset and test control block.
   Assumes the design header and the scan tester model. */
`timescale 1ns/1ps
`include "sys_ctrl_map.vh"
module system_reset_test_control_test;
    localparam HOLD = 8;
    logic        clk, rst_n, cmd, permit, trst_n, tdo_bit;
    logic [2:0]  mode;
    logic [15:0] gpio, drive, dir;
    logic [31:0] id;
    wire         freeze, core_rst_n, func, flt, rsv, tdo, tdo_oe, tck, tms, tdi;
    wire  [15:0] gpio_o, gpio_oe, user_param;
    wire  [4:0]  dline;
    int          n_fail, num_checks, n;
    // ==========================================================
    // Clock, design and scan tester
    always #50 clk = ~clk;
    system_reset_test_control #(.HOLD_CYCLES(HOLD)) dut_u (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_freeze_cmd(cmd),
        .i_debug_permit(permit), .o_freeze(freeze), .o_core_rst_n(core_rst_n),
        .i_test_mode(mode), .o_functional_operation(func),
        .o_outputs_float_mode(flt), .o_reserved_mode(rsv), .i_gpio(gpio),
        .o_gpio(gpio_o), .o_gpio_oe(gpio_oe), .i_gpio_drive(drive),
        .i_gpio_dir(dir), .o_user_param(user_param),
        .o_memory_delay_line(dline), .i_trst_n(trst_n), .i_tck(tck),
        .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe));
    scan_tester tester_u (.i_ref_clk(clk), .i_tdo(tdo), .o_tck(tck),
        .o_tms(tms), .o_tdi(tdi));
    // ==========================================================
    // Compare and report
    task check(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        {clk, rst_n, cmd, permit, trst_n, mode} = 8'h00;
        {gpio, drive, dir} = {16'hC0F5, 16'hA5A5, 16'hFFFF};
        n_fail = 0;
        num_checks = 0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        n = 0;
        while (core_rst_n !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        check("core hold", n, HOLD);
        if (core_rst_n !== 1'b1)
            finish_test;
        check("delay line", dline, 5'h15);
        gpio = 16'h3C0A;
        repeat (2) @(negedge clk);
        check("delay line held", dline, 5'h15);
        check("user param", user_param, 16'h3C0A);
        // Every test-select code with a different pin pattern
        for (int m = 0; m < 8; m++) begin
            mode = m[2:0];
            dir = 16'h1111 << m;
            drive = ~dir;
            @(negedge clk);
            check("functional", func, m == 0);
            check("float", flt, m == 3);
            check("reserved", rsv, m != 0 && m != 3);
            check("pin enable", gpio_oe, m == 3 ? 16'h0000 : dir);
            check("pin drive", gpio_o, drive);
        end
        mode = 3'h0;
        // Freeze needs the permit
        cmd = 1'b1;
        repeat (4) @(negedge clk);
        check("freeze blocked", freeze, 1'b0);
        permit = 1'b1;
        repeat (4) @(negedge clk);
        check("freeze granted", freeze, 1'b1);
        permit = 1'b0;
        repeat (4) @(negedge clk);
        check("freeze dropped", freeze, 1'b0);
        // Scan reset, walk to data shift, read the identity chain
        trst_n = 1'b1;
        for (n = 0; n < 9; n++)
            tester_u.tap_bit(n < 5 || n == 6, 1'b0, tdo_bit);
        for (n = 0; n < 32; n++) begin
            tester_u.tap_bit(n == 31, 1'b1, tdo_bit);
            id[n] = tdo_bit;
        end
        check("identity chain", id, `ID_VALUE);
        // Walk to instruction shift, read the capture, load bypass
        for (n = 0; n < 5; n++)
            tester_u.tap_bit(n < 3, 1'b0, tdo_bit);
        for (n = 0; n < 2; n++) begin
            tester_u.tap_bit(n == 1, 1'b1, tdo_bit);
            id[n] = tdo_bit;
        end
        check("instruction capture", id[1:0], `IR_CAPTURE);
        for (n = 0; n < 4; n++)
            tester_u.tap_bit(n < 2, 1'b0, tdo_bit);
        // Bypass delays each data bit by one scan clock
        for (n = 0; n < 4; n++) begin
            tester_u.tap_bit(1'b0, n != 1, tdo_bit);
            id[n] = tdo_bit;
        end
        check("bypass chain", id[3:0], 4'hA);
        // Scan output enable while shifting, in float mode, and after
        check("scan enable shifting", tdo_oe, 1'b1);
        mode = 3'h3;
        @(negedge clk);
        check("scan enable floated", tdo_oe, 1'b0);
        mode = 3'h0;
        tester_u.tap_bit(1'b0, 1'b0, tdo_bit);
        @(negedge clk);
        check("scan enable restored", tdo_oe, 1'b1);
        tester_u.tap_bit(1'b1, 1'b0, tdo_bit);
        @(negedge clk);
        check("scan enable released", tdo_oe, 1'b0);
        // Board reset in mid-run acts without a clock edge
        rst_n = 1'b0;
        #10;
        check("async core reset", core_rst_n, 1'b0);
        check("async pin enable", gpio_oe, 16'h0000);
        finish_test;
    end
endmodule // system_reset_test_control_test
